// *** hw/aims_pkg.sv ***
// shared constants for the converter input selection block
package aims_pkg;

    // ****************************************
    // bus map
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_SEL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SCAN_SEL = 12'h004;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // ****************************************
    // input select register layout
    // ****************************************
    localparam int NEG_B_BIT = 31;
    localparam int POS_B_LSB = 24;
    localparam int NEG_A_BIT = 23;
    localparam int POS_A_LSB = 16;
    localparam int CODE_W = 4;
    localparam logic [31:0] SAMPLE_SEL_MASK = 32'h8f8f0000;
    localparam logic [31:0] SCAN_SEL_MASK = 32'h0000ffff;
    localparam logic [31:0] SAMPLE_SEL_RESET = 32'h00000000;
    localparam logic [31:0] SCAN_SEL_RESET = 32'h00000000;

    // ****************************************
    // positive input codes and routing
    // ****************************************
    localparam int AN_COUNT = 13;
    localparam logic [3:0] CODE_TEMP = 4'hd;
    localparam logic [3:0] CODE_IREF = 4'he;
    localparam logic [3:0] CODE_OPEN = 4'hf;
    localparam int ROUTE_W = 17;
    localparam int ROUTE_TEMP = 13;
    localparam int ROUTE_IREF = 14;
    localparam int ROUTE_GROUND = 15;
    localparam int ROUTE_LOW_REF = 16;
    localparam logic [16:0] ROUTE_LOW_REF_ONLY = 17'h10000;
    localparam int SCAN_W = 16;

endpackage : aims_pkg

// *** hw/aims_input_decode.sv ***
// decodes a positive input code into a routing vector, one-hot except all zero for code 15 outside a scan
module aims_input_decode
    import aims_pkg::*;
#(
    parameter int PIN_COUNT = 44
)
(
    // code in
    input wire logic [aims_pkg::CODE_W-1:0] code_in,
    input wire logic scan_in,
    // routing out
    output logic [aims_pkg::ROUTE_W-1:0] route_out
);

    logic [AN_COUNT-1:0] absent_hit;

    // ****************************************
    // analog inputs, one per bit
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < AN_COUNT; g++)
        begin : g_an
            localparam bit PRESENT = !((g == 12 && PIN_COUNT != 44) ||
                (g >= 6 && g <= 8 && PIN_COUNT == 28));
            assign route_out[g] = (code_in == 4'(g)) && PRESENT;
            assign absent_hit[g] = (code_in == 4'(g)) && !PRESENT;
        end
    endgenerate

    assign route_out[ROUTE_TEMP] = (code_in == CODE_TEMP);
    assign route_out[ROUTE_IREF] = (code_in == CODE_IREF);
    // code 15 is open for a sample but ground for a scan slot
    assign route_out[ROUTE_GROUND] = scan_in && (code_in == CODE_OPEN);
    // absent inputs convert the low reference rather than a floating node
    assign route_out[ROUTE_LOW_REF] = |absent_hit;

endmodule // aims_input_decode

// *** hw/aims_scan_next.sv ***
// finds the first and the next scan slot in the scan mask
module aims_scan_next
    import aims_pkg::*;
(
    // mask and pointer in
    input wire logic [aims_pkg::SCAN_W-1:0] mask_in,
    input wire logic [3:0] cur_in,
    // slots out
    output logic [3:0] first_out,
    output logic [3:0] next_out
);

    always_comb
    begin
        first_out = 4'h0;
        next_out = cur_in;
        for (int k = SCAN_W - 1; k >= 0; k--)
        begin
            if (mask_in[k])
            begin
                first_out = 4'(k);
            end
        end
        for (int k = SCAN_W; k >= 1; k--)
        begin
            if (mask_in[4'(int'(cur_in) + k)])
            begin
                next_out = 4'(int'(cur_in) + k);
            end
        end
    end

endmodule // aims_scan_next

// *** hw/aims_top.sv ***
// converter input selection: registers on AHB-Lite and sample routing
module aims_top
    import aims_pkg::*;
#(
    parameter int PIN_COUNT = 44
)
(
    // clock, reset, enable
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CLK_EN_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic [1:0] HRESP_OUT,
    // converter controls
    input wire logic ALT_SAMPLE_EN_IN,
    input wire logic SCAN_EN_IN,
    input wire logic OFFSET_CAL_IN,
    input wire logic SAMPLE_START_IN,
    input wire logic SEQ_RESTART_IN,
    // sample and hold routing
    output logic [aims_pkg::ROUTE_W-1:0] POS_ROUTE_OUT,
    output logic NEG_AN1_OUT,
    output logic USING_B_OUT,
    output logic [3:0] SCAN_SLOT_OUT
);

    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (!(PIN_COUNT == 28 || PIN_COUNT == 36 || PIN_COUNT == 44))
        begin : g_bad_pins
            $error("aims_top: PIN_COUNT must be 28, 36 or 44");
        end
    endgenerate

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    // enable low also holds the release back, so nothing moves while frozen
    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************
    // bus slave and registers
    // ****************************************
    logic dp_wr;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] sample_input_select;
    logic [31:0] scan_input_select;
    logic next_dp_wr;
    logic [ADDR_W-1:0] next_dp_addr;
    logic [31:0] next_sample_sel;
    logic [31:0] next_scan_sel;
    logic [31:0] next_rdata;
    logic addr_ok;

    assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

    always_comb
    begin
        next_dp_wr = addr_ok && HWRITE_IN && (HSIZE_IN == HSIZE_WORD);
        next_dp_addr = HADDR_IN[ADDR_W-1:0];
        next_sample_sel = sample_input_select;
        next_scan_sel = scan_input_select;
        if (dp_wr)
        begin
            case (dp_addr)
                OFF_SAMPLE_SEL: next_sample_sel = HWDATA_IN & SAMPLE_SEL_MASK;
                OFF_SCAN_SEL: next_scan_sel = HWDATA_IN & SCAN_SEL_MASK;
                default: ;
            endcase
        end
        // read data uses the next values so a write just ahead is seen
        next_rdata = 32'h00000000;
        if (addr_ok && !HWRITE_IN)
        begin
            case (HADDR_IN[ADDR_W-1:0])
                OFF_SAMPLE_SEL: next_rdata = next_sample_sel;
                OFF_SCAN_SEL: next_rdata = next_scan_sel;
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_wr <= 1'b0;
            dp_addr <= '0;
            sample_input_select <= SAMPLE_SEL_RESET;
            scan_input_select <= SCAN_SEL_RESET;
            HRDATA_OUT <= 32'h00000000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= HRESP_OKAY;
        end
        else if (CLK_EN_IN)
        begin
            dp_wr <= next_dp_wr;
            dp_addr <= next_dp_addr;
            sample_input_select <= next_sample_sel;
            scan_input_select <= next_scan_sel;
            HRDATA_OUT <= next_rdata;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= HRESP_OKAY;
        end
    end

    // ****************************************
    // sample sequencing
    // ****************************************
    logic phase_b;
    logic [3:0] scan_ptr;
    logic next_phase_b;
    logic [3:0] next_scan_ptr;
    logic [ROUTE_W-1:0] next_route;
    logic next_neg;
    logic next_using_b;
    logic [3:0] next_slot;
    logic phase_eff;
    logic [3:0] ptr_eff;
    logic use_b_now;
    logic scan_now;
    logic [3:0] first_slot;
    logic [3:0] after_slot;
    logic [CODE_W-1:0] code_now;
    logic [ROUTE_W-1:0] dec_route;

    assign phase_eff = SEQ_RESTART_IN ? 1'b0 : phase_b;
    assign ptr_eff = SEQ_RESTART_IN ? first_slot : scan_ptr;
    assign use_b_now = ALT_SAMPLE_EN_IN && phase_eff;
    // scanning steers the A setting only; B keeps its fixed code
    assign scan_now = SCAN_EN_IN && !use_b_now;
    assign code_now = scan_now ? ptr_eff :
        (use_b_now ? sample_input_select[POS_B_LSB +: CODE_W] :
        sample_input_select[POS_A_LSB +: CODE_W]);

    aims_scan_next u_scan (
        .mask_in (scan_input_select[SCAN_W-1:0]),
        .cur_in (ptr_eff),
        .first_out (first_slot),
        .next_out (after_slot)
    );

    aims_input_decode #(
        .PIN_COUNT (PIN_COUNT)
    ) u_decode (
        .code_in (code_now),
        .scan_in (scan_now),
        .route_out (dec_route)
    );

    always_comb
    begin
        next_phase_b = phase_eff;
        next_scan_ptr = ptr_eff;
        next_route = POS_ROUTE_OUT;
        next_neg = NEG_AN1_OUT;
        next_using_b = USING_B_OUT;
        next_slot = SCAN_SLOT_OUT;
        if (SAMPLE_START_IN)
        begin
            next_phase_b = ALT_SAMPLE_EN_IN && !use_b_now;
            next_using_b = use_b_now;
            next_slot = ptr_eff;
            if (scan_now)
            begin
                next_scan_ptr = after_slot;
            end
            if (OFFSET_CAL_IN)
            begin
                next_route = ROUTE_LOW_REF_ONLY;
                next_neg = 1'b0;
            end
            else
            begin
                next_route = dec_route;
                next_neg = use_b_now ? sample_input_select[NEG_B_BIT] :
                    sample_input_select[NEG_A_BIT];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_b <= 1'b0;
            scan_ptr <= 4'h0;
            POS_ROUTE_OUT <= '0;
            NEG_AN1_OUT <= 1'b0;
            USING_B_OUT <= 1'b0;
            SCAN_SLOT_OUT <= 4'h0;
        end
        else if (CLK_EN_IN)
        begin
            phase_b <= next_phase_b;
            scan_ptr <= next_scan_ptr;
            POS_ROUTE_OUT <= next_route;
            NEG_AN1_OUT <= next_neg;
            USING_B_OUT <= next_using_b;
            SCAN_SLOT_OUT <= next_slot;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic start_ok;
    logic plain_a;

    assign start_ok = CLK_EN_IN && SAMPLE_START_IN;
    assign plain_a = start_ok && !OFFSET_CAL_IN && !use_b_now && !scan_now;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    a_reserved_read_zero: assert property (addr_ok && CLK_EN_IN && !HWRITE_IN |=>
        (HRDATA_OUT & ~SAMPLE_SEL_MASK & ~SCAN_SEL_MASK) == 32'h00000000)
        else $error("reserved bits read back nonzero");
    a_offset_cal_mode_low_ref: assert property (start_ok && OFFSET_CAL_IN |=>
        POS_ROUTE_OUT == ROUTE_LOW_REF_ONLY && !NEG_AN1_OUT)
        else $error("offset calibration not on low reference");
    a_no_alt_uses_a: assert property (start_ok && !ALT_SAMPLE_EN_IN |=> !USING_B_OUT)
        else $error("B used without alternate mode");
    // first after restart is A and next is B
    a_alt_a_then_b: assert property (start_ok && SEQ_RESTART_IN && ALT_SAMPLE_EN_IN ##1
        (start_ok && ALT_SAMPLE_EN_IN && !SEQ_RESTART_IN) |-> !USING_B_OUT ##1
        USING_B_OUT)
        else $error("alternate order broken");
    a_hold_between: assert property (!start_ok |=> $stable(POS_ROUTE_OUT) &&
        $stable(NEG_AN1_OUT))
        else $error("routing moved without a sampling start");
    a_neg_sel_b: assert property (start_ok && !OFFSET_CAL_IN && use_b_now |=>
        NEG_AN1_OUT == $past(sample_input_select[NEG_B_BIT]))
        else $error("B negative select wrong");
    a_neg_sel_a: assert property (start_ok && !OFFSET_CAL_IN && !use_b_now |=>
        NEG_AN1_OUT == $past(sample_input_select[NEG_A_BIT]))
        else $error("A negative select wrong");
    a_pos_b_temp: assert property (start_ok && !OFFSET_CAL_IN && use_b_now &&
        sample_input_select[POS_B_LSB +: CODE_W] == CODE_TEMP |=>
        POS_ROUTE_OUT == 17'h02000)
        else $error("B temperature code misrouted");
    a_pos_a_open: assert property (plain_a &&
        sample_input_select[POS_A_LSB +: CODE_W] == CODE_OPEN |=>
        POS_ROUTE_OUT == '0)
        else $error("A open code routed something");
    // inputs 6 to 8 only off on small package
    a_absent_input: assert property (plain_a &&
        sample_input_select[POS_A_LSB +: CODE_W] >= 4'h6 &&
        sample_input_select[POS_A_LSB +: CODE_W] <= 4'h8 |=>
        POS_ROUTE_OUT[ROUTE_LOW_REF] == (PIN_COUNT == 28))
        else $error("package input availability wrong");
    a_scan_slot_route: assert property (start_ok && !OFFSET_CAL_IN && scan_now |=>
        POS_ROUTE_OUT[SCAN_SLOT_OUT] || POS_ROUTE_OUT[ROUTE_LOW_REF])
        else $error("scan slot not routed");

endmodule // aims_top

// *** sim/adc_input_mux_select_test.sv ***
// self-checking bench for the converter input selection block
module adc_input_mux_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aims_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    typedef struct packed {
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [16:0] route_a;
        logic neg_a;
        logic [16:0] route_b;
        logic neg_b;
    } aims_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic alt = 1'b0;
    logic scan = 1'b0;
    logic ocal = 1'b0;
    logic start = 1'b0;
    logic restart = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
    logic [16:0] route;
    logic neg;
    logic using_b;
    logic [3:0] slot;
    logic [31:0] rd;
    int fails = 0;
    int total_checks = 0;
    logic [31:0] a_sel = {20'h0, OFF_SAMPLE_SEL};
    logic [31:0] a_scan = {20'h0, OFF_SCAN_SEL};
    // row 1 selects analog_in_12, present on the 44-pin build
    // the open code of row 0 stands for a charge-time measurement
    aims_row_t rows [5] = '{
        '{32'hffffffff, 32'h8f8f0000, 17'h00000, 1'b1, 17'h00000, 1'b1},
        '{32'h0c800000, 32'h0c800000, 17'h00001, 1'b1, 17'h01000, 1'b0},
        '{32'h8d0e7fff, 32'h8d0e0000, 17'h04000, 1'b0, 17'h02000, 1'b1},
        '{32'h01050000, 32'h01050000, 17'h00020, 1'b0, 17'h00002, 1'b0},
        '{32'h89860000, 32'h89860000, 17'h00040, 1'b1, 17'h00200, 1'b1}};
    logic [3:0] slots [4] = '{4'h0, 4'hd, 4'hf, 4'h0};
    logic [16:0] slot_route [4] = '{17'h00001, 17'h02000, 17'h08000, 17'h00001};

    always #12.5 clk = ~clk;

    aims_top #(.PIN_COUNT(44)) dut (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(clk_en),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hreadyout),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
        .ALT_SAMPLE_EN_IN(alt), .SCAN_EN_IN(scan), .OFFSET_CAL_IN(ocal),
        .SAMPLE_START_IN(start), .SEQ_RESTART_IN(restart),
        .POS_ROUTE_OUT(route), .NEG_AN1_OUT(neg), .USING_B_OUT(using_b),
        .SCAN_SLOT_OUT(slot)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // no own limit: the watchdog ends a wait that never sees hready
    task automatic wait_ready;
        do
        begin
            @(posedge clk);
        end
        while (hreadyout !== 1'b1);
    endtask

    // bus, sample and wait_ready are entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [2:0] sz, output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= sz;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask

    task automatic sample(input logic rs, input logic [16:0] er, input logic en,
                          input logic eb);
        start <= 1'b1;
        restart <= rs;
        @(posedge clk);
        start <= 1'b0;
        restart <= 1'b0;
        @(negedge clk);
        check({15'h0, route}, {15'h0, er});
        check({31'h0, neg}, {31'h0, en});
        check({31'h0, using_b}, {31'h0, eb});
        @(posedge clk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        check({31'h0, hreadyout}, 32'h1);
        check({15'h0, route}, 32'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, a_sel, 32'h0, HSIZE_WORD, rd);
        check(rd, SAMPLE_SEL_RESET);
        bus(1'b0, a_scan, 32'h0, HSIZE_WORD, rd);
        check(rd, SCAN_SEL_RESET);
        check({30'h0, hresp}, {30'h0, HRESP_OKAY});
        alt <= 1'b1;
        foreach (rows[i])
        begin
            bus(1'b1, a_sel, rows[i].wdata, HSIZE_WORD, rd);
            bus(1'b0, a_sel, 32'h0, HSIZE_WORD, rd);
            check(rd, rows[i].rdata);
            sample(1'b1, rows[i].route_a, rows[i].neg_a, 1'b0);
            sample(1'b0, rows[i].route_b, rows[i].neg_b, 1'b1);
        end
        sample(1'b0, 17'h00040, 1'b1, 1'b0);
        alt <= 1'b0;
        sample(1'b1, 17'h00040, 1'b1, 1'b0);
        sample(1'b0, 17'h00040, 1'b1, 1'b0);
        bus(1'b1, a_sel, 32'h0, 3'h0, rd);
        bus(1'b1, 32'h00000008, 32'hffffffff, HSIZE_WORD, rd);
        bus(1'b0, 32'h00000008, 32'h0, HSIZE_WORD, rd);
        check(rd, 32'h0);
        bus(1'b0, a_sel, 32'h0, HSIZE_WORD, rd);
        check(rd, 32'h89860000);
        // scan over inputs 0, 13 and ground
        bus(1'b1, a_scan, 32'hffffa001, HSIZE_WORD, rd);
        bus(1'b0, a_scan, 32'h0, HSIZE_WORD, rd);
        check(rd, 32'h0000a001 & SCAN_SEL_MASK);
        scan <= 1'b1;
        foreach (slots[i])
        begin
            sample(i == 0, slot_route[i], 1'b1, 1'b0);
            check({28'h0, slot}, {28'h0, slots[i]});
        end
        ocal <= 1'b1;
        sample(1'b0, ROUTE_LOW_REF_ONLY, 1'b0, 1'b0);
        ocal <= 1'b0;
        scan <= 1'b0;
        // write lands only at the next start
        sample(1'b1, 17'h00040, 1'b1, 1'b0);
        bus(1'b1, a_sel, 32'h0, HSIZE_WORD, rd);
        @(posedge clk);
        check({15'h0, route}, 32'h00040);
        sample(1'b0, 17'h00001, 1'b0, 1'b0);
        // back to back starts: A then B
        alt <= 1'b1;
        start <= 1'b1;
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        check({31'h0, using_b}, 32'h1);
        @(posedge clk);
        clk_en <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        clk_en <= 1'b1;
        start <= 1'b0;
        @(negedge clk);
        check({31'h0, using_b}, 32'h1);
        // reset in mid run clears registers and routing
        @(posedge clk);
        bus(1'b1, a_sel, 32'h89860000, HSIZE_WORD, rd);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        check({31'h0, using_b}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, a_sel, 32'h0, HSIZE_WORD, rd);
        check(rd, SAMPLE_SEL_RESET);
        bus(1'b0, a_scan, 32'h0, HSIZE_WORD, rd);
        check(rd, SCAN_SEL_RESET);
        sample(1'b1, 17'h00001, 1'b0, 1'b0);
        stop_test();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        fails++;
        stop_test();
    end

endmodule // adc_input_mux_select_test
